// [pcu_pkg.sv]
// package: register map, field positions and mode codes of the perf counter
package pcu_pkg;

   localparam int ADDR_W = 8;

   // register byte offsets; each channel owns a block of three words
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_START0 = 8'h04;
   localparam logic [7:0] OFS_END0   = 8'h08;
   localparam logic [7:0] OFS_CNT0   = 8'h0C;
   localparam logic [7:0] CH_STRIDE  = 8'h0C;
   localparam logic [7:0] OFS_STAT   = 8'h1C;

   // control fields
   localparam int          CTRL_CHAIN = 0;
   localparam int          CTRL_ONCE  = 1;
   localparam int          CTRL_CLR   = 2;
   localparam int          CTRL_MODE0 = 4;
   localparam int          MODE_W     = 4;
   localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
   localparam logic [31:0] CTRL_WMASK = 32'h0000_0FF3;

   // status fields
   localparam int ST_OVF = 0;
   localparam int ST_WIN = 4;
   localparam int ST_RUN = 8;

   // widths of the exception and interrupt class vectors
   localparam int N_EXC = 4;
   localparam int N_INT = 3;

   typedef enum logic [3:0] {
      MODE_OFF     = 4'h0,
      MODE_CYC     = 4'h1,
      MODE_SUP     = 4'h2,
      MODE_XI_CYC  = 4'h3,
      MODE_EXC_CYC = 4'h4,
      MODE_INT_CYC = 4'h5,
      MODE_INSTR   = 4'h6,
      MODE_XI_CNT  = 4'h7,
      MODE_EXC_CNT = 4'h8,
      MODE_INT_CNT = 4'h9,
      MODE_EVT     = 4'hA
   } pcu_mode_type;

endpackage

// [pcu_evt_if.sv]
// interface: qualified core event strobes from the qualifier to the channels
interface pcu_evt_if;
   logic        running;
   logic        run_start;
   logic        sup_cyc;
   logic        exc_cyc;
   logic        int_cyc;
   logic        retire;
   logic [31:0] retire_pc;
   logic        exc_acc;
   logic        int_acc;

   modport src (output running, run_start, sup_cyc, exc_cyc, int_cyc,
                output retire, retire_pc, exc_acc, int_acc);
   modport dst (input running, run_start, sup_cyc, exc_cyc, int_cyc,
                input retire, retire_pc, exc_acc, int_acc);
endinterface

// [pcu_evsel.sv]
// core event qualifier: folds exception and interrupt classes into strobes
module pcu_evsel (
   input  wire logic                      sys_clk,
   input  wire logic                      rst,
   input  wire logic                      core_running,
   input  wire logic                      core_supervisor,
   input  wire logic [pcu_pkg::N_EXC-1:0] core_exc_busy,
   input  wire logic [pcu_pkg::N_INT-1:0] core_int_busy,
   input  wire logic [pcu_pkg::N_EXC-1:0] core_exc_take,
   input  wire logic [pcu_pkg::N_INT-1:0] core_int_take,
   input  wire logic                      core_retire,
   input  wire logic [31:0]               core_retire_pc,
   pcu_evt_if.src                         evt
);

   logic run_prev_reg;

   // remembers the run level to find the start of each run
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         run_prev_reg <= 1'b0;
      end else begin
         run_prev_reg <= core_running;
      end
   end

   // class folding and run qualification
   assign evt.running   = core_running;
   assign evt.run_start = core_running && !run_prev_reg;
   assign evt.sup_cyc   = core_running && core_supervisor;
   assign evt.exc_cyc   = |core_exc_busy;
   assign evt.int_cyc   = |core_int_busy;
   assign evt.exc_acc   = |core_exc_take;
   assign evt.int_acc   = |core_int_take;
   assign evt.retire    = core_retire;
   assign evt.retire_pc = core_retire_pc;

endmodule // pcu_evsel

// [pcu_chan.sv]
// one counter channel: mode decode, measurement window and counter
module pcu_chan #(
   parameter int CNT_W = 32
) (
   input  wire logic                       sys_clk,
   input  wire logic                       rst,
   pcu_evt_if.dst                          evt,
   input  wire logic [pcu_pkg::MODE_W-1:0] mode,
   input  wire logic [31:0]                start_pc,
   input  wire logic [31:0]                end_pc,
   input  wire logic                       ev_match,
   input  wire logic                       clr,
   input  wire logic                       chain_lo,
   input  wire logic                       chain_hi,
   input  wire logic                       carry_in,
   output logic      [CNT_W-1:0]           cnt_val,
   output logic                            ovf,
   output logic                            carry_out,
   output logic                            win_open
);

   typedef enum logic [1:0] {
      PCU_WIN_SHUT = 2'b01,
      PCU_WIN_OPEN = 2'b10
   } pcu_win_type;

   pcu_win_type      win_reg;
   logic             hit;
   logic             step;
   logic [CNT_W-1:0] cnt_reg;
   logic             ovf_reg;

   // window opens after the start instruction, shuts after the end one
   always_ff @(posedge sys_clk) begin
      if (rst || clr) begin
         win_reg <= PCU_WIN_SHUT;
      end else begin
         case (win_reg)
            PCU_WIN_SHUT: if (evt.retire && evt.retire_pc == start_pc &&
                              mode != pcu_pkg::MODE_OFF) begin
               win_reg <= PCU_WIN_OPEN;
            end
            PCU_WIN_OPEN: if (evt.retire && evt.retire_pc == end_pc) begin
               win_reg <= PCU_WIN_SHUT;
            end
            default: win_reg <= PCU_WIN_SHUT;
         endcase
      end
   end

   // selects what the channel counts
   always_comb begin
      case (pcu_pkg::pcu_mode_type'(mode))
         pcu_pkg::MODE_CYC:     hit = 1'b1;
         pcu_pkg::MODE_SUP:     hit = evt.sup_cyc;
         pcu_pkg::MODE_XI_CYC:  hit = evt.exc_cyc | evt.int_cyc;
         pcu_pkg::MODE_EXC_CYC: hit = evt.exc_cyc;
         pcu_pkg::MODE_INT_CYC: hit = evt.int_cyc;
         pcu_pkg::MODE_INSTR:   hit = evt.retire;
         pcu_pkg::MODE_XI_CNT:  hit = evt.exc_acc | evt.int_acc;
         pcu_pkg::MODE_EXC_CNT: hit = evt.exc_acc;
         pcu_pkg::MODE_INT_CNT: hit = evt.int_acc;
         pcu_pkg::MODE_EVT:     hit = ev_match;
         default:               hit = 1'b0;
      endcase
   end

   // a chained upper half counts carries only; halted core counts nothing
   assign step = chain_hi ? carry_in
                          : (win_reg == PCU_WIN_OPEN) && evt.running && hit;
   assign carry_out = step && (&cnt_reg);

   // counter keeps its value across halts until cleared
   always_ff @(posedge sys_clk) begin
      if (rst || clr) begin
         cnt_reg <= '0;
      end else if (step) begin
         cnt_reg <= cnt_reg + 1'b1;
      end
   end

   // sticky overflow; a wrap in the clear cycle still sets it
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ovf_reg <= 1'b0;
      end else if (carry_out && !chain_lo) begin
         ovf_reg <= 1'b1;
      end else if (clr) begin
         ovf_reg <= 1'b0;
      end
   end

   assign cnt_val  = cnt_reg;
   assign ovf      = ovf_reg;
   assign win_open = (win_reg == PCU_WIN_OPEN);

endmodule // pcu_chan

// [pcu_top.sv]
// top of the performance counter: apb registers, channels and checks

// Overview of operation
// - a channel whose mode is off never counts, except a chained upper half, which counts carries
// - cycle mode counts every core clock inside the start/stop window
// - supervisor mode counts only cycles spent in supervisor state
// - combined handler mode counts exception or interrupt handler cycles
// - exception cycle mode counts exception handler cycles, not interrupts
// - interrupt cycle mode counts interrupt handler cycles only
// - instruction mode counts one per completed instruction
// - combined accept mode counts each cycle in which an exception or interrupt is accepted
// - exception count mode counts accepted exceptions only
// - interrupt count mode counts accepted interrupts only
// - event mode counts each match of the event condition
// - exceptions are undefined, privileged, float, trap; interrupts nmi, maskable, reset
// - window opens at the start address instruction, closes at the end one
// - counting starts by itself when the core runs user code
// - after halt and resume the count continues, not restarted
// - with single-run set each new run starts from zero
// - large variant has two independent 32-bit counters
// - chaining makes the two counters one 64-bit counter
// - small variant has a single 24-bit counter
// - overflow during measurement is recorded for the host
module pcu_top #(
   parameter int NUM_CH = 2,
   parameter int CNT_W  = 32
) (
   input  wire logic                       sys_clk,
   input  wire logic                       rst,

   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [pcu_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]                pwdata,
   output logic      [31:0]                prdata,
   output logic                            pready,
   output logic                            pslverr,

   input  wire logic                       core_running,
   input  wire logic                       core_supervisor,
   input  wire logic [pcu_pkg::N_EXC-1:0]  core_exc_busy,
   input  wire logic [pcu_pkg::N_INT-1:0]  core_int_busy,
   input  wire logic [pcu_pkg::N_EXC-1:0]  core_exc_take,
   input  wire logic [pcu_pkg::N_INT-1:0]  core_int_take,
   input  wire logic                       core_retire,
   input  wire logic [31:0]                core_retire_pc,
   input  wire logic [NUM_CH-1:0]          ev_match
);

   pcu_evt_if evt ();

   logic [31:0]      ctrl_reg;
   logic [31:0]      start_reg [NUM_CH];
   logic [31:0]      end_reg   [NUM_CH];
   logic [31:0]      hi_shadow_reg;
   logic [31:0]      prdata_reg;
   logic [31:0]      stat_w;
   logic [CNT_W-1:0] cnt_w     [NUM_CH];
   logic [NUM_CH-1:0] ovf_w;
   logic [NUM_CH-1:0] carry_w;
   logic [NUM_CH-1:0] win_w;
   logic             wr_en;
   logic             rd_setup;
   logic             chain_en;
   logic             clr_all;

   // byte offset of a per-channel register
   function automatic logic [7:0] ch_ofs(input logic [7:0] base,
                                         input int         ch);
      ch_ofs = 8'(base + ch * pcu_pkg::CH_STRIDE);
   endfunction

   // true for every offset that holds a register
   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a == pcu_pkg::OFS_CTRL) || (a == pcu_pkg::OFS_STAT);
      for (int i = 0; i < NUM_CH; i++) begin
         if (a == ch_ofs(pcu_pkg::OFS_START0, i) ||
             a == ch_ofs(pcu_pkg::OFS_END0, i) ||
             a == ch_ofs(pcu_pkg::OFS_CNT0, i)) begin
            is_mapped = 1'b1;
         end
      end
   endfunction

   // read data for one offset; unmapped offsets read zero
   function automatic logic [31:0] rd_word(input logic [7:0] a);
      rd_word = 32'h0000_0000;
      if (a == pcu_pkg::OFS_CTRL) begin
         rd_word = ctrl_reg;
      end
      if (a == pcu_pkg::OFS_STAT) begin
         rd_word = stat_w;
      end
      for (int i = 0; i < NUM_CH; i++) begin
         if (a == ch_ofs(pcu_pkg::OFS_START0, i)) begin
            rd_word = start_reg[i];
         end
         if (a == ch_ofs(pcu_pkg::OFS_END0, i)) begin
            rd_word = end_reg[i];
         end
         if (a == ch_ofs(pcu_pkg::OFS_CNT0, i)) begin
            rd_word = (chain_en && i == 1) ? hi_shadow_reg : 32'(cnt_w[i]);
         end
      end
   endfunction

   // apb phase decode; the slave never inserts wait states
   assign wr_en    = psel && penable && pwrite;
   assign rd_setup = psel && !penable && !pwrite;
   assign pready   = 1'b1;
   assign pslverr  = psel && penable && !is_mapped(paddr);
   assign prdata   = prdata_reg;

   // chaining only exists when a second channel does
   assign chain_en = ctrl_reg[pcu_pkg::CTRL_CHAIN] && (NUM_CH > 1);

   // host clear or automatic clear at the start of a single run
   assign clr_all = (wr_en && paddr == pcu_pkg::OFS_CTRL &&
                     pwdata[pcu_pkg::CTRL_CLR]) ||
                    (evt.run_start && ctrl_reg[pcu_pkg::CTRL_ONCE]);

   // status word gathers overflow, window and run state
   always_comb begin
      stat_w = 32'h0000_0000;
      for (int i = 0; i < NUM_CH; i++) begin
         stat_w[pcu_pkg::ST_OVF + i] = ovf_w[i];
         stat_w[pcu_pkg::ST_WIN + i] = win_w[i];
      end
      stat_w[pcu_pkg::ST_RUN] = core_running;
   end

   // event qualifier
   pcu_evsel u_sel (
      .sys_clk        (sys_clk),
      .rst            (rst),
      .core_running   (core_running),
      .core_supervisor(core_supervisor),
      .core_exc_busy  (core_exc_busy),
      .core_int_busy  (core_int_busy),
      .core_exc_take  (core_exc_take),
      .core_int_take  (core_int_take),
      .core_retire    (core_retire),
      .core_retire_pc (core_retire_pc),
      .evt            (evt)
   );

   // counter channels: two 32-bit by default, one 24-bit for the small part
   for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
      pcu_chan #(
         .CNT_W(CNT_W)
      ) u_ch (
         .sys_clk  (sys_clk),
         .rst      (rst),
         .evt      (evt),
         .mode     (ctrl_reg[pcu_pkg::CTRL_MODE0 + i * pcu_pkg::MODE_W +: pcu_pkg::MODE_W]),
         .start_pc (start_reg[i]),
         .end_pc   (end_reg[i]),
         .ev_match (ev_match[i]),
         .clr      (clr_all),
         .chain_lo (chain_en && i == 0),
         .chain_hi (chain_en && i == 1),
         .carry_in ((i > 0) && carry_w[(i > 0) ? i - 1 : 0]),
         .cnt_val  (cnt_w[i]),
         .ovf      (ovf_w[i]),
         .carry_out(carry_w[i]),
         .win_open (win_w[i])
      );
   end

   // control register: mode fields, chaining and single-run option
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ctrl_reg <= pcu_pkg::CTRL_RST;
      end else if (wr_en && paddr == pcu_pkg::OFS_CTRL) begin
         ctrl_reg <= pwdata & pcu_pkg::CTRL_WMASK;
      end
   end

   // window address registers of each channel
   for (genvar i = 0; i < NUM_CH; i++) begin : g_adr
      always_ff @(posedge sys_clk) begin
         if (rst) begin
            start_reg[i] <= 32'h0000_0000;
            end_reg[i]   <= 32'h0000_0000;
         end else if (wr_en) begin
            if (paddr == ch_ofs(pcu_pkg::OFS_START0, i)) begin
               start_reg[i] <= pwdata;
            end
            if (paddr == ch_ofs(pcu_pkg::OFS_END0, i)) begin
               end_reg[i] <= pwdata;
            end
         end
      end
   end

   // upper half is frozen when the lower half is read, for a torn-free pair
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         hi_shadow_reg <= 32'h0000_0000;
      end else if (rd_setup && paddr == pcu_pkg::OFS_CNT0) begin
         hi_shadow_reg <= 32'(cnt_w[NUM_CH - 1]);
      end
   end

   // read data is registered in the setup phase
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         prdata_reg <= 32'h0000_0000;
      end else if (rd_setup) begin
         prdata_reg <= rd_word(paddr);
      end
   end

   // checks on channel 0, the second channel alone and the chained pair
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);

   logic [pcu_pkg::MODE_W-1:0] mode0;
   logic                       quiet0;
   logic [pcu_pkg::MODE_W-1:0] mode1;

   assign mode0  = ctrl_reg[pcu_pkg::CTRL_MODE0 +: pcu_pkg::MODE_W];
   assign mode1  = ctrl_reg[pcu_pkg::CTRL_MODE0 + pcu_pkg::MODE_W +: pcu_pkg::MODE_W];
   assign quiet0 = !clr_all && !(&cnt_w[0]);

   chk_off_idle: assert property (
      mode0 == pcu_pkg::MODE_OFF && !clr_all |=> $stable(cnt_w[0]))
      else $error("counter moved while its mode is off");

   chk_cyc_step: assert property (
      mode0 == pcu_pkg::MODE_CYC && win_w[0] && core_running && quiet0
      |=> cnt_w[0] == $past(cnt_w[0]) + 1'b1)
      else $error("cycle mode missed a cycle");

   chk_sup_gate: assert property (
      mode0 == pcu_pkg::MODE_SUP && !core_supervisor && !clr_all
      |=> $stable(cnt_w[0]))
      else $error("supervisor mode counted a user cycle");

   chk_exc_only: assert property (
      mode0 == pcu_pkg::MODE_EXC_CYC && !(|core_exc_busy) && !clr_all
      |=> $stable(cnt_w[0]))
      else $error("exception cycle mode counted outside a handler");

   chk_int_only: assert property (
      mode0 == pcu_pkg::MODE_INT_CYC && !(|core_int_busy) && !clr_all
      |=> $stable(cnt_w[0]))
      else $error("interrupt cycle mode counted outside a handler");

   chk_instr_step: assert property (
      mode0 == pcu_pkg::MODE_INSTR && win_w[0] && core_running &&
      core_retire && quiet0
      |=> cnt_w[0] == $past(cnt_w[0]) + 1'b1)
      else $error("instruction mode missed a retirement");

   chk_win_open: assert property (
      !win_w[0] && core_retire && core_retire_pc == start_reg[0] &&
      mode0 != pcu_pkg::MODE_OFF && !clr_all
      |=> win_w[0])
      else $error("window did not open at the start address");

   chk_win_shut: assert property (
      win_w[0] && core_retire && core_retire_pc == end_reg[0]
      |=> !win_w[0])
      else $error("window did not close at the end address");

   chk_halt_hold: assert property (
      !core_running && !clr_all [*2]
      |-> $stable(cnt_w[0]) && $stable(cnt_w[NUM_CH - 1]))
      else $error("count changed while the core was halted");

   chk_once_clear: assert property (
      evt.run_start && ctrl_reg[pcu_pkg::CTRL_ONCE] && !carry_w[0]
      |=> cnt_w[0] == '0 && ovf_w[0] == 1'b0 && !win_w[0])
      else $error("single run did not start from zero");

   chk_wrap_flag: assert property (
      mode0 == pcu_pkg::MODE_CYC && win_w[0] && core_running &&
      (&cnt_w[0]) && !chain_en
      |=> ovf_w[0] && cnt_w[0] == '0)
      else $error("wrap did not raise the overflow flag");

   chk_ovf_sticky: assert property (
      ovf_w[0] && !clr_all |=> ovf_w[0])
      else $error("overflow flag dropped without a clear");

   chk_chain_carry: assert property (
      chain_en && carry_w[0] && !clr_all
      |=> cnt_w[NUM_CH - 1] == $past(cnt_w[NUM_CH - 1]) + 1'b1 &&
          cnt_w[0] == '0 && $stable(ovf_w[0]))
      else $error("chained halves did not carry");

   chk_xi_gate: assert property (
      mode0 == pcu_pkg::MODE_XI_CYC && !(|core_exc_busy) && !(|core_int_busy) &&
      !clr_all |=> $stable(cnt_w[0]))
      else $error("handler cycle mode counted outside a handler");

   chk_acc_step: assert property (
      mode0 == pcu_pkg::MODE_XI_CNT && win_w[0] && core_running &&
      ((|core_exc_take) || (|core_int_take)) && quiet0
      |=> cnt_w[0] == $past(cnt_w[0]) + 1'b1)
      else $error("accept mode missed an acceptance");

   chk_exc_count: assert property (
      mode0 == pcu_pkg::MODE_EXC_CNT && !(|core_exc_take) && !clr_all
      |=> $stable(cnt_w[0]))
      else $error("exception count mode counted without an exception");

   chk_int_count: assert property (
      mode0 == pcu_pkg::MODE_INT_CNT && !(|core_int_take) && !clr_all
      |=> $stable(cnt_w[0]))
      else $error("interrupt count mode counted without an interrupt");

   chk_evt_step: assert property (
      mode0 == pcu_pkg::MODE_EVT && win_w[0] && core_running && ev_match[0] && quiet0
      |=> cnt_w[0] == $past(cnt_w[0]) + 1'b1)
      else $error("event mode missed a match");

   chk_shut_idle: assert property (
      !win_w[0] && !clr_all |=> $stable(cnt_w[0]))
      else $error("counter moved with its window shut");

   chk_ch1_alone: assert property (
      NUM_CH > 1 && !chain_en && mode1 == pcu_pkg::MODE_OFF && !clr_all
      |=> $stable(cnt_w[NUM_CH - 1]))
      else $error("second counter moved while its mode is off");

   chk_host_clear: assert property (
      wr_en && paddr == pcu_pkg::OFS_CTRL && pwdata[pcu_pkg::CTRL_CLR]
      |=> cnt_w[0] == '0 && !win_w[0])
      else $error("host clear left a count or an open window");

   // main scenarios worth seeing in simulation
   cov_window: cover property (
      !win_w[0] ##1 win_w[0] [*6] ##1 !win_w[0]);

   cov_overflow: cover property (!ovf_w[0] ##1 ovf_w[0]);

   cov_chain: cover property (chain_en && carry_w[0]);

   cov_once: cover property (
      evt.run_start && ctrl_reg[pcu_pkg::CTRL_ONCE]);

endmodule // pcu_top

// [pcu_core_model.sv]
// partner model of the core: run state, handler levels and event strobes
module pcu_core_model (
   input  wire logic sys_clk,
   output logic      core_running,
   output logic      core_supervisor,
   output logic [3:0]  core_exc_busy,
   output logic [2:0]  core_int_busy,
   output logic [3:0]  core_exc_take,
   output logic [2:0]  core_int_take,
   output logic        core_retire,
   output logic [31:0] core_retire_pc,
   output logic [1:0]  ev_match
);
   timeunit 1ns;
   timeprecision 1ps;
   // quiet core at time zero
   initial begin
      core_retire_pc = 32'h0;
      cyc0();
   end
   task automatic cyc0();
      core_running = 1'b0;
      {core_supervisor, core_exc_busy, core_int_busy} = 8'h0;
      {core_exc_take, core_int_take, core_retire, ev_match} = 10'h0;
   endtask
   // one core cycle: drive every line, then wait for the edge
   task automatic cyc(input logic r, input logic s, input logic [3:0] eb,
                      input logic [2:0] ib, input logic [3:0] et, input logic [2:0] it,
                      input logic rt, input logic [31:0] pc, input logic [1:0] ev);
      core_running    <= r;
      core_supervisor <= s;
      core_exc_busy   <= eb;
      core_int_busy   <= ib;
      core_exc_take   <= et;
      core_int_take   <= it;
      core_retire     <= rt;
      core_retire_pc  <= rt ? pc : ~core_retire_pc; // pc toggles while not valid
      ev_match        <= ev;
      @(posedge sys_clk);
   endtask
   task automatic idle(input int n);
      repeat (n) cyc(1'b1, 1'b0, 4'h0, 3'h0, 4'h0, 3'h0, 1'b0, 32'h0, 2'h0);
   endtask
   task automatic hit(input logic [31:0] pc);
      cyc(1'b1, 1'b0, 4'h0, 3'h0, 4'h0, 3'h0, 1'b1, pc, 2'h0);
   endtask
   task automatic halt();
      cyc(1'b0, 1'b0, 4'h0, 3'h0, 4'h0, 3'h0, 1'b0, 32'h0, 2'h0);
   endtask
   // 20 cycles: 3 supervisor, each handler class once, each accept once, 5 retires
   task automatic play();
      for (int i = 0; i < 20; i++) begin
         cyc(1'b1, i < 3, (i >= 3 && i < 7) ? 4'h1 << (i - 3) : 4'h0,
             (i >= 7 && i < 10) ? 3'h1 << (i - 7) : 3'h0,
             (i >= 10 && i < 14) ? 4'h1 << (i - 10) : 4'h0,
             (i >= 14 && i < 17) ? 3'h1 << (i - 14) : 3'h0,
             i % 4 == 0, 32'h0, (i == 17 || i == 18) ? 2'h1 : (i == 19) ? 2'h2 : 2'h0);
      end
   endtask
endmodule // pcu_core_model

// [cpu_performance_counter_tb.sv]
// testbench of the performance counter: apb tasks and core scenarios
module cpu_performance_counter_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        sys_clk;
   logic        rst;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        run, sup, ret;
   logic [3:0]  eb, et;
   logic [2:0]  ib, it;
   logic [31:0] rpc;
   logic [1:0]  evm;
   logic [31:0] q;
   logic [31:0] q2;
   logic [31:0] prdata_s;
   logic        e;
   int          miscompares;
   int          num_checks;
   localparam logic [31:0] A = 32'h0000_1000;
   localparam logic [31:0] B = 32'h0000_2000;
   localparam logic [7:0]  CNT1 = pcu_pkg::OFS_CNT0 + pcu_pkg::CH_STRIDE;
   localparam logic [31:0] CLR = 32'h1 << pcu_pkg::CTRL_CLR;
   logic [31:0] exp_cnt [12] = '{32'h0, 32'h14, 32'h3, 32'h7, 32'h4, 32'h3,
                                 32'h5, 32'h7, 32'h4, 32'h3, 32'h2, 32'h0};

   pcu_top dut (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .core_running(run), .core_supervisor(sup),
      .core_exc_busy(eb), .core_int_busy(ib), .core_exc_take(et), .core_int_take(it),
      .core_retire(ret), .core_retire_pc(rpc), .ev_match(evm));
   // short counters, so that wrap, overflow and the chained carry are reached in a short run
   pcu_top #(.NUM_CH(2), .CNT_W(4)) dut_small (.sys_clk(sys_clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata_s),
      .pready(), .pslverr(), .core_running(run), .core_supervisor(sup),
      .core_exc_busy(eb), .core_int_busy(ib), .core_exc_take(et), .core_int_take(it),
      .core_retire(ret), .core_retire_pc(rpc), .ev_match(evm));
   pcu_core_model core (.sys_clk(sys_clk), .core_running(run), .core_supervisor(sup),
      .core_exc_busy(eb), .core_int_busy(ib), .core_exc_take(et), .core_int_take(it),
      .core_retire(ret), .core_retire_pc(rpc), .ev_match(evm));

   // 40 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] want);
      num_checks++;
      if (got !== want) begin
         miscompares++;
         $display("[FAIL] %0t: got %h want %h", $time, got, want);
      end
   endtask
   // apb transfer: setup, access until pready, then release
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      q = prdata;
      q2 = prdata_s;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] want);
      apb(1'b0, a, 32'h0);
      chk(q, want);
   endtask
   // read from both instances, each against its own expected value
   task automatic rd2(input logic [7:0] a, input logic [31:0] want, input logic [31:0] want_s);
      apb(1'b0, a, 32'h0);
      chk(q, want);
      chk(q2, want_s);
   endtask
   // start run, hit start address, count 3 cycles, halt
   task automatic run3();
      core.idle(1);
      core.hit(A);
      core.idle(3);
      core.halt();
   endtask
   task automatic close_out();
      $display("checks %0d, miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // hang guard, well beyond the expected run
   initial begin
      #(25 * 4000);
      miscompares++;
      close_out();
   end
   // main sequence
   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h0;
      pwdata = 32'h0;
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      rd(pcu_pkg::OFS_CTRL, 32'h0);
      rd(pcu_pkg::OFS_STAT, 32'h0);
      rd(8'h20, 32'h0);
      chk({31'h0, e}, 32'h1);
      wr(pcu_pkg::OFS_START0, A);
      wr(pcu_pkg::OFS_END0, B);
      for (int m = 0; m < 12; m++) begin
         wr(pcu_pkg::OFS_CTRL, CLR);
         wr(pcu_pkg::OFS_CTRL, 32'(m) << pcu_pkg::CTRL_MODE0);
         core.idle(1);
         core.hit(A);
         core.play();
         core.halt();
         rd(pcu_pkg::OFS_CNT0, exp_cnt[m]);
      end
      wr(pcu_pkg::OFS_CNT0, 32'hFFFF_FFFF);
      rd(pcu_pkg::OFS_CNT0, 32'h0);
      wr(pcu_pkg::OFS_CTRL, CLR);
      wr(pcu_pkg::OFS_CTRL, 32'h10);
      core.idle(1);
      core.hit(A);
      core.idle(5);
      core.hit(B);
      core.idle(3);
      core.halt();
      rd(pcu_pkg::OFS_CNT0, 32'h6);
      run3();
      rd(pcu_pkg::OFS_CNT0, 32'h9);
      wr(pcu_pkg::OFS_CTRL, 32'h12);
      run3();
      rd(pcu_pkg::OFS_CNT0, 32'h3);
      run3();
      rd(pcu_pkg::OFS_CNT0, 32'h3);
      rd(pcu_pkg::OFS_CNT0 + pcu_pkg::CH_STRIDE, 32'h0);
      // second channel alone: cycles on channel 0, event matches on channel 1
      wr(pcu_pkg::OFS_START0 + pcu_pkg::CH_STRIDE, A);
      wr(pcu_pkg::OFS_END0 + pcu_pkg::CH_STRIDE, B);
      wr(pcu_pkg::OFS_CTRL, CLR);
      wr(pcu_pkg::OFS_CTRL, 32'h0000_0A10);
      core.idle(1);
      core.hit(A);
      core.play();
      core.halt();
      rd2(pcu_pkg::OFS_CNT0, 32'h14, 32'h4);
      rd2(CNT1, 32'h1, 32'h1);
      // chained pair: 20 cycles, then 241 more to wrap the short upper half
      wr(pcu_pkg::OFS_CTRL, CLR);
      wr(pcu_pkg::OFS_CTRL, 32'h0000_0011);
      core.idle(1);
      core.hit(A);
      core.idle(20);
      core.halt();
      rd2(pcu_pkg::OFS_CNT0, 32'h14, 32'h4);
      rd2(CNT1, 32'h0, 32'h1);
      core.idle(241);
      core.halt();
      rd2(pcu_pkg::OFS_CNT0, 32'h105, 32'h5);
      rd2(CNT1, 32'h0, 32'h0);
      rd2(pcu_pkg::OFS_STAT, 32'h10, 32'h12);
      close_out();
   end
endmodule // cpu_performance_counter_tb
